// ### logic/mbra_pkg.sv
// constants and state types of the modbus register access responder
package mbra_pkg;

    // ****************************************
    // operation and exception codes
    // ****************************************
    localparam logic [7:0] MBRA_OP_RD_HOLD  = 8'h03;
    localparam logic [7:0] MBRA_OP_RD_INPUT = 8'h04;
    localparam logic [7:0] MBRA_OP_WR_ONE   = 8'h06;
    localparam logic [7:0] MBRA_OP_WR_MANY  = 8'h10;
    localparam logic [7:0] MBRA_ERR_FLAG    = 8'h80;
    localparam logic [7:0] MBRA_EXC_FUNC    = 8'h01;
    localparam logic [7:0] MBRA_EXC_VALUE   = 8'h03;

    // ****************************************
    // limits and frame layout
    // ****************************************
    localparam logic [15:0] MBRA_RD_MAX      = 16'h007D;
    localparam logic [15:0] MBRA_WR_MAX      = 16'h007B;
    localparam logic [8:0]  MBRA_FIXED_LEN   = 9'h008;
    localparam logic [8:0]  MBRA_MANY_BASE   = 9'h009;
    localparam logic [8:0]  MBRA_MIN_LEN     = 9'h004;
    localparam logic [8:0]  MBRA_BUF_BYTES   = 9'h100;
    localparam logic [8:0]  MBRA_VAL_OFFSET  = 9'h007;
    localparam int          MBRA_HDR_BYTES   = 7;
    localparam logic [7:0]  MBRA_SHORT_HDR   = 8'h03;
    localparam logic [7:0]  MBRA_LONG_HDR    = 8'h06;
    localparam int          MBRA_FIFO_DEPTH  = 32;

    // ****************************************
    // check value
    // ****************************************
    localparam logic [15:0] MBRA_CRC_INIT    = 16'hFFFF;
    localparam logic [15:0] MBRA_CRC_POLY    = 16'hA001;
    localparam logic [15:0] MBRA_CRC_GOOD    = 16'h0000;

    typedef enum logic [3:0] {
        MBRA_S_RX     = 4'h0,
        MBRA_S_CHECK  = 4'h1,
        MBRA_S_WR     = 4'h2,
        MBRA_S_HDR    = 4'h3,
        MBRA_S_RDREQ  = 4'h4,
        MBRA_S_RDWAIT = 4'h5,
        MBRA_S_RDCAP  = 4'h6,
        MBRA_S_RDHI   = 4'h7,
        MBRA_S_RDLO   = 4'h8,
        MBRA_S_CRCL   = 4'h9,
        MBRA_S_CRCH   = 4'hA
    } mbra_state_t;

endpackage

// ### logic/mbra_fifo.sv
// reply byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module mbra_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   fill;
    } mbra_fifo_st_t;

    mbra_fifo_st_t q;
    mbra_fifo_st_t d;
    logic [W-1:0]  mem [DEPTH];
    logic          push;
    logic          pop;

    assign in_ready_out  = (q.fill != DEPTH[AW:0]);
    assign out_valid_out = (q.fill != '0);
    assign out_data_out  = mem[q.rp];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop)
        begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        d.fill = q.fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // storage has no reset; the fill count guards every read
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[q.wp] <= in_data_in;
        end
    end
endmodule

// ### logic/mbra_top.sv
// modbus rtu register access decoder and responder
`timescale 1ns/1ps
module mbra_top #(
    parameter int FIFO_DEPTH = mbra_pkg::MBRA_FIFO_DEPTH
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  station_addr_in,
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic        rx_frame_end_in,
    output logic [15:0]      reg_addr_out,
    output logic [15:0]      reg_wdata_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    input  wire logic [15:0] reg_rdata_in,
    output logic             tx_valid_out,
    output logic [7:0]       tx_data_out,
    input  wire logic        tx_ready_in
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        mbra_pkg::mbra_state_t st;
        logic [8:0]            cnt;
        logic [15:0]           crc;
        logic                  ovf;
        logic [8:0]            len;
        logic [7:0]            idx;
        logic [7:0]            nreg;
        logic [7:0]            exc;
        logic                  rdop;
        logic [15:0]           hold;
        logic [15:0]           txcrc;
        logic [15:0]           addr;
        logic [15:0]           wdata;
        logic                  wr;
        logic                  rd;
    } mbra_st_t;

    mbra_st_t   q;
    mbra_st_t   d;
    logic [7:0] buf_mem [256];
    logic [7:0] hdr [mbra_pkg::MBRA_HDR_BYTES];
    logic       push_valid;
    logic       push_ready;
    logic [7:0] push_data;
    logic [7:0] op;
    logic [15:0] fld_a;
    logic [15:0] fld_n;
    logic [8:0] val_a;
    logic       rx_take;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ mbra_pkg::MBRA_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // big-endian request fields
    assign op      = hdr[1];
    assign fld_a   = {hdr[2], hdr[3]};
    assign fld_n   = {hdr[4], hdr[5]};
    assign val_a   = mbra_pkg::MBRA_VAL_OFFSET + {q.idx, 1'b0};
    assign rx_take = (q.st == mbra_pkg::MBRA_S_RX) && rx_valid_in && !rx_frame_end_in
                     && (q.cnt != mbra_pkg::MBRA_BUF_BYTES);

    // ****************************************
    // frame store
    // ****************************************
    // header bytes kept in flops so decode reads them all at once
    always_ff @(posedge clk_in)
    begin
        if (rx_take)
        begin
            buf_mem[q.cnt[7:0]] <= rx_data_in;
            if (q.cnt < 9'(mbra_pkg::MBRA_HDR_BYTES))
            begin
                hdr[q.cnt[2:0]] <= rx_data_in;
            end
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        d          = q;
        d.wr       = 1'b0;
        d.rd       = 1'b0;
        push_valid = 1'b0;
        push_data  = 8'h00;
        unique case (q.st)
            mbra_pkg::MBRA_S_RX:
            begin
                if (rx_frame_end_in)
                begin
                    // silent drop: short, overrun, bad check or foreign station
                    if (q.cnt >= mbra_pkg::MBRA_MIN_LEN && !q.ovf
                        && q.crc == mbra_pkg::MBRA_CRC_GOOD
                        && hdr[0] == station_addr_in)
                    begin
                        d.st = mbra_pkg::MBRA_S_CHECK;
                    end
                    d.len = q.cnt;
                    d.cnt = '0;
                    d.crc = mbra_pkg::MBRA_CRC_INIT;
                    d.ovf = 1'b0;
                end
                else if (rx_take)
                begin
                    d.cnt = q.cnt + 9'h001;
                    d.crc = crc_byte(q.crc, rx_data_in);
                end
                else if (rx_valid_in)
                begin
                    d.ovf = 1'b1;
                end
            end
            mbra_pkg::MBRA_S_CHECK:
            begin
                d.idx   = 8'h00;
                d.exc   = 8'h00;
                d.txcrc = mbra_pkg::MBRA_CRC_INIT;
                d.addr  = fld_a;
                d.nreg  = fld_n[7:0];
                d.rdop  = 1'b0;
                if (op == mbra_pkg::MBRA_OP_RD_HOLD || op == mbra_pkg::MBRA_OP_RD_INPUT)
                begin
                    d.rdop = 1'b1;
                    if (q.len != mbra_pkg::MBRA_FIXED_LEN || fld_n == 16'h0000
                        || fld_n > mbra_pkg::MBRA_RD_MAX)
                    begin
                        d.exc = mbra_pkg::MBRA_EXC_VALUE;
                    end
                end
                else if (op == mbra_pkg::MBRA_OP_WR_ONE)
                begin
                    d.nreg = 8'h01;
                    if (q.len != mbra_pkg::MBRA_FIXED_LEN)
                    begin
                        d.exc = mbra_pkg::MBRA_EXC_VALUE;
                    end
                end
                else if (op == mbra_pkg::MBRA_OP_WR_MANY)
                begin
                    if (fld_n == 16'h0000 || fld_n > mbra_pkg::MBRA_WR_MAX
                        || hdr[6] != {fld_n[6:0], 1'b0}
                        || q.len != mbra_pkg::MBRA_MANY_BASE + {fld_n[7:0], 1'b0})
                    begin
                        d.exc = mbra_pkg::MBRA_EXC_VALUE;
                    end
                end
                else
                begin
                    d.exc = mbra_pkg::MBRA_EXC_FUNC;
                end
                d.st = (d.exc == 8'h00 && !d.rdop) ? mbra_pkg::MBRA_S_WR
                                                    : mbra_pkg::MBRA_S_HDR;
            end
            mbra_pkg::MBRA_S_WR:
            begin
                d.wr    = 1'b1;
                d.wdata = (op == mbra_pkg::MBRA_OP_WR_ONE) ? fld_n
                        : {buf_mem[val_a[7:0]], buf_mem[val_a[7:0] + 8'h01]};
                d.addr  = q.wr ? q.addr + 16'h0001 : q.addr;
                d.idx   = q.idx + 8'h01;
                if (q.idx + 8'h01 == q.nreg)
                begin
                    d.idx = 8'h00;
                    d.st  = mbra_pkg::MBRA_S_HDR;
                end
            end
            mbra_pkg::MBRA_S_HDR:
            begin
                push_valid = 1'b1;
                // writes echo request bytes 0..5; reads and errors send 3 bytes
                push_data  = (q.idx == 8'h01 && q.exc != 8'h00) ? op | mbra_pkg::MBRA_ERR_FLAG
                           : (q.idx == 8'h02 && q.exc != 8'h00) ? q.exc
                           : (q.idx == 8'h02 && q.rdop) ? {q.nreg[6:0], 1'b0}
                           : hdr[q.idx[2:0]];
                if (push_ready)
                begin
                    d.txcrc = crc_byte(q.txcrc, push_data);
                    d.idx   = q.idx + 8'h01;
                    if (q.idx + 8'h01 == ((q.rdop || q.exc != 8'h00)
                        ? mbra_pkg::MBRA_SHORT_HDR : mbra_pkg::MBRA_LONG_HDR))
                    begin
                        d.idx  = 8'h00;
                        d.addr = fld_a;
                        d.st   = (q.rdop && q.exc == 8'h00) ? mbra_pkg::MBRA_S_RDREQ
                                                            : mbra_pkg::MBRA_S_CRCL;
                    end
                end
            end
            mbra_pkg::MBRA_S_RDREQ:
            begin
                d.rd = 1'b1;
                d.st = mbra_pkg::MBRA_S_RDWAIT;
            end
            mbra_pkg::MBRA_S_RDWAIT:
            begin
                d.st = mbra_pkg::MBRA_S_RDCAP;
            end
            mbra_pkg::MBRA_S_RDCAP:
            begin
                d.hold = reg_rdata_in;
                d.st   = mbra_pkg::MBRA_S_RDHI;
            end
            mbra_pkg::MBRA_S_RDHI:
            begin
                push_valid = 1'b1;
                push_data  = q.hold[15:8];
                if (push_ready)
                begin
                    d.txcrc = crc_byte(q.txcrc, push_data);
                    d.st    = mbra_pkg::MBRA_S_RDLO;
                end
            end
            mbra_pkg::MBRA_S_RDLO:
            begin
                push_valid = 1'b1;
                push_data  = q.hold[7:0];
                if (push_ready)
                begin
                    d.txcrc = crc_byte(q.txcrc, push_data);
                    d.addr  = q.addr + 16'h0001;
                    d.idx   = q.idx + 8'h01;
                    d.st    = (q.idx + 8'h01 == q.nreg) ? mbra_pkg::MBRA_S_CRCL
                                                        : mbra_pkg::MBRA_S_RDREQ;
                end
            end
            mbra_pkg::MBRA_S_CRCL:
            begin
                push_valid = 1'b1;
                push_data  = q.txcrc[7:0];
                if (push_ready)
                begin
                    d.st = mbra_pkg::MBRA_S_CRCH;
                end
            end
            mbra_pkg::MBRA_S_CRCH:
            begin
                push_valid = 1'b1;
                push_data  = q.txcrc[15:8];
                if (push_ready)
                begin
                    d.st = mbra_pkg::MBRA_S_RX;
                end
            end
            default:
            begin
                d.st = mbra_pkg::MBRA_S_RX;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q       <= '0;
            q.crc   <= mbra_pkg::MBRA_CRC_INIT;
            q.txcrc <= mbra_pkg::MBRA_CRC_INIT;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_addr_out  = q.addr;
    assign reg_wdata_out = q.wdata;
    assign reg_wr_out    = q.wr;
    assign reg_rd_out    = q.rd;

    // ****************************************
    // reply buffer
    // ****************************************
    // a stalled line back-pressures the sequencer, never drops bytes
    mbra_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (push_ready),
        .in_data_in    (push_data),
        .out_valid_out (tx_valid_out),
        .out_ready_in  (tx_ready_in),
        .out_data_out  (tx_data_out)
    );
endmodule

// ### bench/mbra_props.sv
// assertion checker for the register access responder
`timescale 1ns/1ps
module mbra_props #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  station_addr_in,
    input wire logic        rx_valid_in,
    input wire logic [7:0]  rx_data_in,
    input wire logic        rx_frame_end_in,
    input wire logic [15:0] reg_addr_out,
    input wire logic [15:0] reg_wdata_out,
    input wire logic        reg_wr_out,
    input wire logic        reg_rd_out,
    input wire logic [15:0] reg_rdata_in,
    input wire logic        tx_valid_out,
    input wire logic [7:0]  tx_data_out,
    input wire logic        tx_ready_in
);
    // ********************
    // properties
    // ********************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_rd_gap;
        reg_rd_out |=> !reg_rd_out [*4];
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
    property p_rd_wr;
        !(reg_rd_out && reg_wr_out);
    endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("read and write together");
    property p_wr_up;
        reg_wr_out && $past(reg_wr_out) |-> reg_addr_out == $past(reg_addr_out) + 16'h0001;
    endproperty
    a_wr_up: assert property (p_wr_up) else $error("write burst not ascending");
    property p_wr_late;
        rx_frame_end_in |-> !reg_wr_out [*2];
    endproperty
    a_wr_late: assert property (p_wr_late) else $error("write before decode");
    property p_rd_late;
        rx_frame_end_in |-> !reg_rd_out [*3];
    endproperty
    a_rd_late: assert property (p_rd_late) else $error("read before header");
    property p_tx_late;
        rx_frame_end_in && !tx_valid_out |=> !tx_valid_out [*2];
    endproperty
    a_tx_late: assert property (p_tx_late) else $error("reply before check");
    property p_tx_hold;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply byte not held");
    property p_rd_push;
        reg_rd_out |-> ##[0:8] tx_valid_out;
    endproperty
    a_rd_push: assert property (p_rd_push) else $error("read value not queued");
    c_burst: cover property (reg_wr_out ##1 reg_wr_out);
    c_read: cover property (reg_rd_out);
    c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule
bind mbra_top mbra_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .clk_in(clk_in), .rst_in(rst_in), .station_addr_in(station_addr_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .rx_frame_end_in(rx_frame_end_in),
    .reg_addr_out(reg_addr_out), .reg_wdata_out(reg_wdata_out), .reg_wr_out(reg_wr_out),
    .reg_rd_out(reg_rd_out), .reg_rdata_in(reg_rdata_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in)
);

// ### bench/mbra_master.sv
// bus master model: sends requests, takes replies with random stalls
`timescale 1ns/1ps
module mbra_master (
    input  wire logic       clk_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_ready_out,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_frame_end_out
);
    logic [7:0] got[$];
    logic [7:0] byte_q = 8'h00;
    logic [7:0] idle_q = 8'h00;
    bit         slow = 1'b0;
    initial
    begin
        tx_ready_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_frame_end_out = 1'b0;
    end
    // idle line moves every cycle so a stale byte cannot pass as valid
    assign rx_data_out = rx_valid_out ? byte_q : idle_q;
    always @(posedge clk_in)
    begin
        idle_q <= #1 idle_q + 8'h35;
        if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1)
            got.push_back(tx_data_in);
        tx_ready_out <= #1 slow ? ($urandom % 6 == 0) : ($urandom % 4 != 0);
    end
    // ********************
    // check value and frame sending
    // ********************
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i])
        begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i])
        begin
            @(posedge clk_in);
            #1 rx_valid_out = 1'b1;
            byte_q = f[i];
        end
        @(posedge clk_in);
        #1 rx_valid_out = 1'b0;
        rx_frame_end_out = 1'b1;
        @(posedge clk_in);
        #1 rx_frame_end_out = 1'b0;
        // single server on the line, so a short gap stands in for the long one
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// ### bench/testbench.sv
// self-checking bench of the register access responder
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0, rst = 1'b1, rx_v, rx_e, txr, wr, rd, txv;
    logic [7:0] st = 8'h00, rx_d, txd;
    logic [15:0] ra, rw, rdat = 16'h0000;
    logic [7:0] er[$];
    logic [31:0] ew[$], wl[$];
    int n_mismatch = 0, check_count = 0;
    initial forever #2.5 clk_in = ~clk_in;
    mbra_top #(.FIFO_DEPTH(32)) dut (
        .clk_in(clk_in), .rst_in(rst), .station_addr_in(st), .rx_valid_in(rx_v),
        .rx_data_in(rx_d), .rx_frame_end_in(rx_e), .reg_addr_out(ra), .reg_wdata_out(rw),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdat), .tx_valid_out(txv),
        .tx_data_out(txd), .tx_ready_in(txr)
    );
    mbra_master u_m (
        .clk_in(clk_in), .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr),
        .rx_valid_out(rx_v), .rx_data_out(rx_d), .rx_frame_end_out(rx_e)
    );
    // register space: value derived from address, line moves when not read
    always @(posedge clk_in)
    begin
        rdat <= #1 (rd === 1'b1) ? (ra ^ 16'hC35A) : ~rdat;
        if (wr === 1'b1)
            wl.push_back({ra, rw});
    end
    // ********************
    // reference model
    // ********************
    function automatic void model(input logic [7:0] f[$]);
        logic [15:0] a, n, c;
        logic [7:0] op, ex;
        int k;
        k = f.size();
        er = {};
        ew = {};
        if (k < 4 || k > 256 || u_m.crc16(f) !== 16'h0000 || f[0] !== st)
            return;
        op = f[1];
        a = {f[2], f[3]};
        n = {f[4], f[5]};
        ex = 8'h00;
        if (op == 8'h03 || op == 8'h04)
            ex = (k != 8 || n < 1 || n > 16'h007D) ? 8'h03 : 8'h00;
        else if (op == 8'h06)
            ex = (k != 8) ? 8'h03 : 8'h00;
        else if (op == 8'h10)
            ex = (n < 1 || n > 16'h007B || f[6] != 2 * n || k != 9 + 2 * n) ? 8'h03 : 8'h00;
        else
            ex = 8'h01;
        if (ex != 8'h00)
            er = {f[0], op | 8'h80, ex};
        else if (op < 8'h05)
        begin
            er = {f[0], op, 8'(2 * n)};
            for (int i = 0; i < n; i++)
            begin
                c = (a + i[15:0]) ^ 16'hC35A;
                er.push_back(c[15:8]);
                er.push_back(c[7:0]);
            end
        end
        else
        begin
            er = f[0:5];
            if (op == 8'h06)
                ew.push_back({a, n});
            else
                for (int i = 0; i < n; i++)
                    ew.push_back({a + i[15:0], f[7 + 2 * i], f[8 + 2 * i]});
        end
        c = u_m.crc16(er);
        er.push_back(c[7:0]);
        er.push_back(c[15:8]);
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic run(input logic [7:0] f[$], input bit bad);
        logic [15:0] c;
        int t;
        c = u_m.crc16(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8] ^ {7'h00, bad});
        model(f);
        u_m.got.delete();
        wl.delete();
        u_m.send(f);
        for (t = 0; t < 4000 && u_m.got.size() < er.size(); t++)
            @(posedge clk_in);
        repeat (30) @(posedge clk_in);
        cmp(u_m.got.size(), er.size());
        foreach (er[i])
            if (i < u_m.got.size())
                cmp(u_m.got[i], er[i]);
        cmp(wl.size(), ew.size());
        foreach (ew[i])
            if (i < wl.size())
                cmp(wl[i], ew[i]);
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #300000;
        n_mismatch++;
        conclude();
    end
    // ********************
    // scenarios
    // ********************
    initial
    begin
        logic [7:0] f[$];
        logic [7:0] n;
        logic [15:0] a;
        void'($urandom(72));
        st = 8'($urandom_range(247, 1));
        repeat (20) @(posedge clk_in);
        #1 rst = 1'b0;
        run({st, 8'h03, 8'h13, 8'h88, 8'h00, 8'h02}, 0);
        for (int k = 0; k < 4; k++)
        begin
            a = 16'($urandom()) & 16'hFFFE;
            u_m.slow = k[0];
            run({st, k[1] ? 8'h04 : 8'h03, a[15:8], a[7:0], 8'h00, k[0] ? 8'h7D : 8'h01}, 0);
        end
        u_m.slow = 0;
        run({st, 8'h03, 8'hFF, 8'hFE, 8'h00, 8'h03}, 0);
        run({st, 8'h04, 8'h00, 8'h10, 8'h00, 8'h7E}, 0);
        run({st, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00}, 0);
        a = 16'($urandom());
        run({st, 8'h06, a[15:8], a[7:0], 8'h5A, 8'hC3}, 0);
        run({st, 8'h06, 8'h17, 8'h70, 8'h00}, 0);
        for (int k = 0; k < 2; k++)
        begin
            n = k ? 8'h7B : 8'h02;
            a = 16'($urandom());
            f = {st, 8'h10, a[15:8], a[7:0], 8'h00, n, 8'(n * 2)};
            repeat (2 * n) f.push_back(8'($urandom()));
            run(f, 0);
        end
        run({st, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, 0);
        run({st, 8'h10, 8'h00, 8'h10, 8'h00, 8'h01, 8'h04, 8'hAA, 8'hBB}, 0);
        run({st, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
        run({st, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02}, 1);
        run({st ^ 8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02}, 0);
        conclude();
    end
endmodule
